// file: rtl/nss_shift9.sv
// Operation
// (R1) nine serial lanes share one shift clock and move one nine-bit word per step.
// (R2) lane depth is a build parameter of 80, 100, 128, 132 or 133, equal for all lanes.
// (R3) each falling shift clock edge enters one bit per lane and advances every stored bit.
// (R4) with the shift clock held low nothing changes, whatever data and recirculate do.
// (R5) recirculate low at a falling edge feeds each lane output back into its input.
// (R6) recirculate high at a falling edge enters the external data bit of each lane.
// (R7) while recirculating the outputs stay valid and the data inputs are ignored.
// (R8) master clear high forces every bit of every lane low in either clock state.
// (R9) the far side releases master clear 250 ns before the rising edge ahead of new data.
// (R10) the far side holds master clear high for at least 40 us.
// (R11) the far side runs the shift clock from standstill up to 1.5 MHz; state is static.
// (R12) the far side keeps clock high 300 to 100000 ns and clock low at least 300 ns.
// (R13) a bit entered shows at the lane output after as many falling edges as the depth.
//
// Purpose: nine-lane static shift register with a tap FIFO on the output stream
// Assumes: all pins synchronous to clk; ce low freezes every flip-flop
// Notes:   timing_fault flags far-side clock and clear timing misuse
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// tap fifo
// -----------------------------------------------------------------
module nss_fifo
  import nss_pkg::*;
#(
  parameter int W     = NSS_LANES,
  parameter int DEPTH = NSS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             cnt;
    logic                    in_rdy;
    logic                    o_vld;
    logic [W-1:0]            o_dat;
  } nss_fifo_st_t;

  nss_fifo_st_t s_reg;
  nss_fifo_st_t s_next;

  logic take_out;
  logic push;

  always_comb begin
    s_next   = s_reg;
    take_out = ~s_reg.o_vld | out_ready;
    push     = in_valid & s_reg.in_rdy;
    if (take_out) begin
      if (s_reg.cnt != '0) begin
        s_next.o_dat  = s_reg.mem[s_reg.rd_ptr];
        s_next.o_vld  = 1'b1;
        s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      end else begin
        s_next.o_vld = 1'b0;
      end
    end
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = in_data;
      s_next.wr_ptr            = s_reg.wr_ptr + 1'b1;
    end
    s_next.cnt = s_reg.cnt + {{AW{1'b0}}, push}
               - {{AW{1'b0}}, take_out && (s_reg.cnt != '0)};
    s_next.in_rdy = (s_next.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg        <= '0;
      s_reg.in_rdy <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign in_ready  = s_reg.in_rdy;
  assign out_valid = s_reg.o_vld;
  assign out_data  = s_reg.o_dat;

endmodule

// -----------------------------------------------------------------
// saturating cycle timer
// -----------------------------------------------------------------
module nss_sat_cnt
  import nss_pkg::*;
#(
  parameter int           W    = NSS_CNT_W,
  parameter logic [W-1:0] RST  = '1,
  parameter logic [W-1:0] LOAD = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // control
  input  wire logic         load,
  input  wire logic         inc,
  // count
  output logic [W-1:0]      cnt
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } nss_cnt_st_t;

  nss_cnt_st_t s_reg;
  nss_cnt_st_t s_next;

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.cnt = LOAD;
    end else if (inc && (s_reg.cnt != {W{1'b1}})) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg.cnt <= RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign cnt = s_reg.cnt;

endmodule

// -----------------------------------------------------------------
// shift register top
// -----------------------------------------------------------------
module nss_shift9
  import nss_pkg::*;
#(
  parameter int DEPTH      = NSS_DEPTH_DEF, // R2
  parameter int FIFO_DEPTH = NSS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  // device pins
  input  wire logic                 shift_clk,
  input  wire logic                 recirc,
  input  wire logic                 mclr,
  input  wire logic [NSS_LANES-1:0] din,
  output logic      [NSS_LANES-1:0] dout,
  // tap stream of words leaving the lanes
  output logic                      tap_valid,
  output logic      [NSS_LANES-1:0] tap_data,
  input  wire logic                 tap_ready,
  output logic                      tap_space,
  output logic                      tap_drop,
  // status
  output logic                      timing_fault
);

  localparam int CW = NSS_CNT_W;

  // one word per step across all lanes (R1)
  typedef logic [DEPTH-1:0][NSS_LANES-1:0] nss_lanes_t;

  typedef struct packed {
    nss_lanes_t    stage;
    logic          clk_q;
    logic          clr_q;
    logic          fault;
    logic          drop;
  } nss_top_st_t;

  localparam nss_top_st_t ST_RST = '{
    stage:   {DEPTH{ {NSS_LANES{NSS_BIT_RST}} }},
    clk_q:   1'b0,
    clr_q:   1'b0,
    fault:   1'b0,
    drop:    1'b0
  };

  nss_top_st_t s_reg;
  nss_top_st_t s_next;

  logic                 fall;
  logic                 rise;
  logic                 push;
  logic                 fifo_rdy;
  logic [NSS_LANES-1:0] in_word;
  logic [CW-1:0]        ph_cnt;
  logic [CW-1:0]        clr_cnt;
  logic [CW-1:0]        rel_cnt;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    fall         = s_reg.clk_q & ~shift_clk;
    rise         = ~s_reg.clk_q & shift_clk;
    push         = 1'b0;
    in_word      = s_reg.stage[DEPTH-1];
    s_next.clk_q = shift_clk;
    s_next.clr_q = mclr;
    s_next.drop  = 1'b0;

    // shift clock phase timing
    if (fall && (ph_cnt < NSS_HIGH_MIN_CYC ||
                 ph_cnt > NSS_HIGH_MAX_CYC)) begin
      s_next.fault = 1'b1; // R12
    end
    if (rise && ph_cnt < NSS_LOW_MIN_CYC) begin
      s_next.fault = 1'b1; // R12
    end

    // master clear width and release timing
    if (!mclr && s_reg.clr_q && clr_cnt < NSS_CLR_WIDTH_CYC) begin
      s_next.fault = 1'b1; // R10
    end
    if (rise && !mclr && rel_cnt < NSS_CLR_SETUP_CYC) begin
      s_next.fault = 1'b1; // R9
    end

    // lanes
    if (mclr) begin
      s_next.stage = '0; // R8
    end else if (fall) begin // R3 R4 R11
      in_word = recirc ? din : s_reg.stage[DEPTH-1]; // R5 R6 R7
      push    = 1'b1;
      s_next.stage = {s_reg.stage[DEPTH-2:0], in_word}; // R3 R13
      s_next.drop  = ~fifo_rdy;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg <= ST_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  // length of the current shift clock phase
  nss_sat_cnt #(
    .W    (CW),
    .RST  (NSS_CNT_MAX),
    .LOAD (CW'(1))
  ) u_ph_cnt (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .load   (fall | rise),
    .inc    (1'b1),
    .cnt    (ph_cnt)
  );

  // width of the running clear pulse
  nss_sat_cnt #(
    .W    (CW),
    .RST  ('0),
    .LOAD ('0)
  ) u_clr_cnt (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .load   (~mclr & s_reg.clr_q),
    .inc    (mclr),
    .cnt    (clr_cnt)
  );

  // time since clear was released
  nss_sat_cnt #(
    .W    (CW),
    .RST  (NSS_CNT_MAX),
    .LOAD ('0)
  ) u_rel_cnt (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .load   (mclr),
    .inc    (1'b1),
    .cnt    (rel_cnt)
  );

  // ---------------------------------------------------------------
  // tap fifo
  // ---------------------------------------------------------------
  nss_fifo #(
    .W     (NSS_LANES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (push),
    .in_data   (s_reg.stage[DEPTH-1]),
    .in_ready  (fifo_rdy),
    .out_valid (tap_valid),
    .out_data  (tap_data),
    .out_ready (tap_ready)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dout         = s_reg.stage[DEPTH-1]; // R13
  assign tap_space    = fifo_rdy;
  assign tap_drop     = s_reg.drop;
  assign timing_fault = s_reg.fault;

endmodule

`default_nettype wire

// file: rtl/nss_pkg.sv
// Purpose: shared constants for the nine-lane static shift register
// Assumes: system clock of 20 MHz, device pins sampled on it
// Notes:   counts are derived from the printed times in this package
package nss_pkg;

  // ---------------------------------------------------------------
  // structure
  // ---------------------------------------------------------------
  localparam int NSS_LANES      = 9;
  localparam int NSS_DEPTH_DEF  = 128;
  localparam int NSS_FIFO_DEPTH = 32;
  localparam logic NSS_BIT_RST  = 1'b0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int NSS_CLK_MHZ        = 20;
  localparam int NSS_CNT_W          = 12;
  localparam int NSS_CLR_SETUP_NS   = 250;
  localparam int NSS_CLR_WIDTH_US   = 40;
  localparam int NSS_HIGH_MIN_NS    = 300;
  localparam int NSS_HIGH_MAX_NS    = 100000;
  localparam int NSS_LOW_MIN_NS     = 300;

  localparam logic [NSS_CNT_W-1:0] NSS_CNT_MAX = 12'hfff;
  localparam logic [NSS_CNT_W-1:0] NSS_CLR_SETUP_CYC =
    NSS_CNT_W'((NSS_CLR_SETUP_NS * NSS_CLK_MHZ + 999) / 1000);
  localparam logic [NSS_CNT_W-1:0] NSS_CLR_WIDTH_CYC =
    NSS_CNT_W'(NSS_CLR_WIDTH_US * NSS_CLK_MHZ);
  localparam logic [NSS_CNT_W-1:0] NSS_HIGH_MIN_CYC =
    NSS_CNT_W'((NSS_HIGH_MIN_NS * NSS_CLK_MHZ + 999) / 1000);
  localparam logic [NSS_CNT_W-1:0] NSS_HIGH_MAX_CYC =
    NSS_CNT_W'((NSS_HIGH_MAX_NS * NSS_CLK_MHZ) / 1000);
  localparam logic [NSS_CNT_W-1:0] NSS_LOW_MIN_CYC =
    NSS_CNT_W'((NSS_LOW_MIN_NS * NSS_CLK_MHZ + 999) / 1000);

endpackage

// file: testbench/nss_shift9_assertions.sv
// Purpose: port assertions for nss_shift9
// Assumes: a shift step is a sampled fall of shift_clk
// Notes:   bound to every nss_shift9
`timescale 1ns/1ps
`default_nettype none
module nss_shift9_chk
  import nss_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 ce,
  input wire logic                 shift_clk,
  input wire logic                 mclr,
  input wire logic [NSS_LANES-1:0] dout,
  input wire logic                 tap_valid,
  input wire logic [NSS_LANES-1:0] tap_data,
  input wire logic                 tap_ready,
  input wire logic                 tap_space,
  input wire logic                 tap_drop,
  input wire logic                 timing_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence short_hi_s;
    $rose(shift_clk) ##1 shift_clk ##1 !shift_clk && ce && !mclr;
  endsequence
  hold_still_a: assert property (
    !(ce && $fell(shift_clk)) && !mclr |=> $stable(dout)
  ) else $error("dout moved");
  clear_zero_a: assert property (
    ce && mclr |=> dout == '0
  ) else $error("not cleared");
  tap_rise_a: assert property (
    ce && $fell(shift_clk) && !mclr && !tap_valid |-> ##[1:3] tap_valid
  ) else $error("tap late");
  drop_seen_a: assert property (
    ce && $fell(shift_clk) && !mclr && !tap_space |-> ##[1:2] tap_drop
  ) else $error("no drop");
  no_drop_a: assert property (
    ce && $fell(shift_clk) && !mclr && tap_space |=> !tap_drop
  ) else $error("false drop");
  tap_hold_a: assert property (
    ce && tap_valid && !tap_ready |=> tap_valid && $stable(tap_data)
  ) else $error("tap unstable");
  fault_set_a: assert property (short_hi_s |=> timing_fault)
    else $error("fault missed");
  fault_keep_a: assert property (timing_fault |=> timing_fault)
    else $error("fault lost");
endmodule
bind nss_shift9 nss_shift9_chk u_chk (
  .clk          (clk),
  .resetn       (resetn),
  .ce           (ce),
  .shift_clk    (shift_clk),
  .mclr         (mclr),
  .dout         (dout),
  .tap_valid    (tap_valid),
  .tap_data     (tap_data),
  .tap_ready    (tap_ready),
  .tap_space    (tap_space),
  .tap_drop     (tap_drop),
  .timing_fault (timing_fault)
);
`default_nettype wire

// file: testbench/nss_far_side.sv
// Purpose: far-side logic driving the nss_shift9 pins
// Assumes: tasks start just after a clk edge
// Notes:   released inputs swing to the inverse level
`timescale 1ns/1ps
`default_nettype none
module nss_far_side
  import nss_pkg::*;
(
  input  wire logic                 clk,
  output logic                      shift_clk,
  output logic                      recirc,
  output logic                      mclr,
  output logic      [NSS_LANES-1:0] din
);
  initial {shift_clk, recirc, mclr, din} = '0;
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic r, input logic [NSS_LANES-1:0] d, input int hi, lo);
    {shift_clk, recirc, din} = {1'b1, r, d};
    wait_n(hi);
    shift_clk = 1'b0;
    wait_n(3);
    {recirc, din} = ~{r, d};
    wait_n(lo - 3);
  endtask
  task automatic clear(input logic lvl);
    {shift_clk, mclr} = {lvl, 1'b1};
    wait_n(int'(NSS_CLR_WIDTH_CYC) - 1);
    shift_clk = 1'b0;
    wait_n(1);
    mclr = 1'b0;
    wait_n(6);
  endtask
endmodule
`default_nettype wire

// file: testbench/nss_shift9_tb.sv
// Purpose: self-checking bench for nss_shift9
// Assumes: lanes 80 deep, far-side model drives the pins
// Notes:   q mirrors the lanes, tq the tap stream
`timescale 1ns/1ps
`default_nettype none
module nss_shift9_tb
  import nss_pkg::*;
;
  typedef logic [NSS_LANES-1:0] nss_word_t;
  localparam int DEPTH = 80;
  localparam int TAP_N = NSS_FIFO_DEPTH + 4;
  logic      clk = 1'b0;
  logic      resetn = 1'b0;
  logic      tap_ready = 1'b0;
  logic      ce = 1'b1;
  logic      sclk_q = 1'b0;
  logic      shift_clk, recirc, mclr, tap_valid, tap_space, tap_drop, timing_fault;
  nss_word_t din, dout, tap_data;
  nss_word_t q[$], tq[$];
  int        fail_count, comparisons, drop_seen;
  always #25 clk = ~clk;
  nss_far_side u_far (.clk(clk), .shift_clk(shift_clk), .recirc(recirc), .mclr(mclr),
    .din(din));
  nss_shift9 #(.DEPTH(DEPTH)) u_dut (.clk(clk), .resetn(resetn), .ce(ce),
    .shift_clk(shift_clk), .recirc(recirc), .mclr(mclr), .din(din), .dout(dout),
    .tap_valid(tap_valid), .tap_data(tap_data), .tap_ready(tap_ready),
    .tap_space(tap_space), .tap_drop(tap_drop), .timing_fault(timing_fault));
  task automatic check(input nss_word_t got, input nss_word_t exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (resetn && ce && !shift_clk && sclk_q && !mclr && tap_space) tq.push_back(q[$]);
    if (tap_drop) drop_seen++;
    if (tap_valid && tap_ready) check(tap_data, tq.pop_front());
    sclk_q <= shift_clk;
  end
  task automatic do_step(input logic r, input nss_word_t d, input int lo);
    u_far.step(r, d, 8, lo);
    q.push_front(r ? d : q[$]);
    void'(q.pop_back());
    check(dout, q[$]);
  endtask
  task automatic t_fill();
    for (int k = 0; k < DEPTH + 4; k++) do_step(1'b1, 9'(k * 37 + 5), 6);
    $display("fill done");
  endtask
  task automatic t_recirc();
    for (int k = 0; k < DEPTH + 3; k++) do_step(1'b0, 9'(k), 6);
    $display("recirculate done");
  endtask
  task automatic t_hold();
    do_step(1'b1, 9'h1a5, 400);
    $display("hold done");
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    u_far.step(1'b1, 9'h0aa, 8, 6);
    ce = 1'b1;
    u_far.wait_n(2);
    check(dout, q[$]);
    do_step(1'b1, 9'h055, 6);
    $display("freeze done");
  endtask
  task automatic t_clear();
    u_far.clear(1'b1);
    foreach (q[i]) q[i] = '0;
    check(dout, '0);
    do_step(1'b1, 9'h1ff, 6);
    $display("clear done");
  endtask
  task automatic t_tap();
    tap_ready = 1'b0;
    drop_seen = 0;
    for (int k = 0; k < TAP_N; k++) do_step(1'b1, 9'(k), 6);
    check(9'(drop_seen), 9'(TAP_N - NSS_FIFO_DEPTH - 1));
    tap_ready = 1'b1;
    for (int i = 0; i < 100 && tap_valid !== 1'b0; i++) u_far.wait_n(1);
    check(9'(tq.size()), 9'h0);
    $display("tap done");
  endtask
  task automatic t_fault();
    check(9'(timing_fault), 9'h0);
    u_far.step(1'b1, 9'h0, 2, 6);
    check(9'(timing_fault), 9'h1);
    $display("fault done");
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    fail_count++;
    print_verdict();
  end
  initial begin
    for (int i = 0; i < DEPTH; i++) q.push_back('0);
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    tap_ready = 1'b1;
    t_fill();
    t_recirc();
    t_freeze();
    t_hold();
    t_clear();
    t_tap();
    t_fault();
    print_verdict();
  end
endmodule
`default_nettype wire
